// ### include/gpl_pkg.sv
// Constants for the two-pin configuration block with disable-register lock
package gpl_pkg;
  // Printed register indices; byte address is four times the index
  localparam logic [7:0] GPL_EVT_IDX = 8'h3d;
  localparam logic [7:0] GPL_LCK_IDX = 8'h3e;
  localparam logic [9:0] GPL_EVT_ADDR = {GPL_EVT_IDX, 2'b00};
  localparam logic [9:0] GPL_LCK_ADDR = {GPL_LCK_IDX, 2'b00};
  localparam int GPL_ADDR_W = 10;
  // Reset values on standby power-on reset
  localparam logic [7:0] GPL_EVT_RST = 8'h01;
  localparam logic [7:0] GPL_LCK_RST = 8'h01;
  // Field positions
  localparam int GPL_DIR_BIT = 0;
  localparam int GPL_POL_BIT = 1;
  localparam int GPL_ALT_BIT = 2;
  localparam int GPL_FN_LSB = 2;
  localparam int GPL_FN_MSB = 3;
  localparam int GPL_OD_BIT = 7;
  // Implemented bits; the rest are reserved and read as zero
  localparam logic [7:0] GPL_EVT_MASK = 8'h87;
  localparam logic [7:0] GPL_LCK_MASK = 8'h8f;
  // Function codes of the lockable pin
  localparam logic [1:0] GPL_FN_GPIO = 2'h0;
  localparam logic [1:0] GPL_FN_LOCK = 2'h1;
  localparam logic [1:0] GPL_FN_SHARE = 2'h2;
  localparam logic [1:0] GPL_FN_EDGE = 2'h3;
  // AHB encodings
  localparam logic [1:0] GPL_HTRANS_NONSEQ = 2'h2;
  localparam logic GPL_HRESP_OKAY = 1'b0;
endpackage : gpl_pkg

// ### core/gpl_pin_cfg.sv
// Configuration logic for the event-capable pin and the lockable pin
`timescale 1ns/1ps
module gpl_pin_cfg (
  // AHB-Lite clock and standby power-on reset
  input wire logic hclk,
  input wire logic hresetn,
  // Further resets, synchronous, active high
  input wire logic main_power_on_reset,
  input wire logic hard_reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [gpl_pkg::GPL_ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Event-capable pin
  input wire logic event_capable_pin_level,
  output logic event_capable_pin_drive,
  output logic event_capable_pin_oe,
  input wire logic event_pin_data,
  input wire logic power_event_active,
  output logic event_pin_value,
  output logic power_event_out_n,
  // Lockable pin
  input wire logic lockable_pin_level,
  output logic lockable_pin_drive,
  output logic lockable_pin_oe,
  input wire logic lock_pin_data,
  output logic lock_pin_value,
  // Lockable pin functions
  input wire logic share_event_enable,
  output logic floppy_parallel_share_select,
  output logic lock_pin_edge_event,
  output logic disable_register_lock_ctrl,
  output logic disable_register_writable
);
  import gpl_pkg::*;

  logic [7:0] evt_cfg_q;
  logic [7:0] evt_cfg_d;
  logic [7:0] lck_cfg_q;
  logic [7:0] lck_cfg_d;
  logic wr_pend_q;
  logic [GPL_ADDR_W-1:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic evt_level_q;
  logic lck_level_q;
  logic lck_value_q;
  logic lck_seen_q;

  // Drive logic shared by both pins: returns {drive, oe}
  function automatic logic [1:0] pin_drive(input logic is_input, input logic value,
                                           input logic open_drain);
    logic [1:0] r;
    r = 2'b00;
    if (!is_input) begin
      if (open_drain) begin
        r = {1'b0, ~value};
      end else begin
        r = {value, 1'b1};
      end
    end
    return r;
  endfunction : pin_drive

  // Bus decode
  wire addr_phase = hsel & hready & (htrans == GPL_HTRANS_NONSEQ);
  wire wr_evt = wr_pend_q & (wr_addr_q == GPL_EVT_ADDR);
  wire wr_lck = wr_pend_q & (wr_addr_q == GPL_LCK_ADDR);
  wire [7:0] wbyte = hwdata[7:0];

  // Lockable pin field decode
  wire [1:0] lck_fn = lck_cfg_q[GPL_FN_MSB:GPL_FN_LSB];
  wire lock_mode = (lck_fn == GPL_FN_LOCK);
  wire fn_clear = main_power_on_reset | hard_reset;
  // Field stays at 01 once there; only a reset moves it
  wire [1:0] fn_wr = lock_mode ? GPL_FN_LOCK : wbyte[GPL_FN_MSB:GPL_FN_LSB];
  wire [7:0] lck_wr = {wbyte[7:4], fn_wr, wbyte[1:0]} & GPL_LCK_MASK;

  assign evt_cfg_d = wr_evt ? (wbyte & GPL_EVT_MASK) : evt_cfg_q;

  always_comb begin
    lck_cfg_d = wr_lck ? lck_wr : lck_cfg_q;
    if (fn_clear) begin
      lck_cfg_d[GPL_FN_MSB:GPL_FN_LSB] = GPL_FN_GPIO;
    end
  end

  // Read data taken from next values so a write just before a read is seen
  wire [7:0] rd_byte = (haddr == GPL_EVT_ADDR) ? evt_cfg_d :
                       (haddr == GPL_LCK_ADDR) ? lck_cfg_d : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_q <= haddr;
      end
      if (addr_phase && !hwrite) begin
        hrdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Standby POR restores both registers, function field included
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_cfg_q <= GPL_EVT_RST;
      lck_cfg_q <= GPL_LCK_RST;
    end else begin
      evt_cfg_q <= evt_cfg_d;
      lck_cfg_q <= lck_cfg_d;
    end
  end

  // Zero-wait slave, always OKAY; hsize ignored as only word transfers occur
  assign hreadyout = 1'b1;
  assign hresp = GPL_HRESP_OKAY;
  assign hrdata = hrdata_q;

  // Pin sampling, one flop since inputs are synchronous to hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_level_q <= 1'b0;
      lck_level_q <= 1'b0;
      lck_value_q <= 1'b0;
      lck_seen_q <= 1'b0;
    end else begin
      evt_level_q <= event_capable_pin_level;
      lck_level_q <= lockable_pin_level;
      lck_value_q <= lock_pin_value;
      lck_seen_q <= 1'b1;
    end
  end

  // Event-capable pin
  wire evt_is_in = evt_cfg_q[GPL_DIR_BIT];
  wire evt_pol = evt_cfg_q[GPL_POL_BIT];
  wire evt_alt = evt_cfg_q[GPL_ALT_BIT];
  assign power_event_out_n = ~power_event_active;
  wire evt_src = evt_alt ? power_event_out_n : event_pin_data;
  wire evt_out = evt_src ^ evt_pol;
  wire [1:0] evt_drv = pin_drive(evt_is_in, evt_out, evt_cfg_q[GPL_OD_BIT]);
  assign event_capable_pin_drive = evt_drv[1];
  assign event_capable_pin_oe = evt_drv[0];
  assign event_pin_value = evt_level_q ^ evt_pol;

  // Lockable pin; lock mode overrides direction and polarity
  wire lck_is_in = lck_cfg_q[GPL_DIR_BIT] | lock_mode;
  wire lck_pol = lck_cfg_q[GPL_POL_BIT] & ~lock_mode;
  wire lck_out = lock_pin_data ^ lck_pol;
  wire [1:0] lck_drv = pin_drive(lck_is_in, lck_out, lck_cfg_q[GPL_OD_BIT]);
  assign lockable_pin_drive = lck_drv[1];
  assign lockable_pin_oe = lck_drv[0];
  assign lock_pin_value = lck_level_q ^ lck_pol;

  // Share select follows the polarity-adjusted level
  assign floppy_parallel_share_select = (lck_fn == GPL_FN_SHARE) & lock_pin_value;

  // Either-edge events; first cycle after reset is masked to avoid a false edge
  wire lck_edge = lck_seen_q & (lock_pin_value ^ lck_value_q);
  wire edge_mode = (lck_fn == GPL_FN_EDGE);
  wire share_irq = (lck_fn == GPL_FN_SHARE) & share_event_enable;
  assign lock_pin_edge_event = lck_edge & (edge_mode | share_irq);

  // Disable register write permission, raw pin level
  assign disable_register_lock_ctrl = lock_mode;
  assign disable_register_writable = ~(lock_mode & lck_level_q);

endmodule : gpl_pin_cfg

// ### dv/gpl_checker.sv
// Port assertions for the two-pin configuration block
`timescale 1ns/1ps
module gpl_checker (
  // Clock and resets
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic main_power_on_reset,
  input wire logic hard_reset,
  // Pins and functions
  input wire logic power_event_active,
  input wire logic power_event_out_n,
  input wire logic lockable_pin_level,
  input wire logic lockable_pin_oe,
  input wire logic lock_pin_value,
  input wire logic lock_pin_edge_event,
  input wire logic disable_register_lock_ctrl,
  input wire logic disable_register_writable
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_pme_low: assert property (power_event_out_n != power_event_active)
    else $error("event out polarity");
  a_lock_input: assert property (disable_register_lock_ctrl |-> !lockable_pin_oe)
    else $error("lock pin driven");
  a_lock_plain: assert property (disable_register_lock_ctrl && $past(disable_register_lock_ctrl)
    |-> lock_pin_value == $past(lockable_pin_level)) else $error("lock pin value");
  a_lock_sticky: assert property (disable_register_lock_ctrl && !main_power_on_reset
    && !hard_reset |=> disable_register_lock_ctrl) else $error("lock field lost");
  a_reset_clear: assert property (main_power_on_reset || hard_reset
    |=> !disable_register_lock_ctrl) else $error("lock field kept");
  a_lock_ro: assert property (disable_register_lock_ctrl && lockable_pin_level
    && $past(lockable_pin_level) |-> !disable_register_writable) else $error("writable");
  a_lock_rw: assert property (disable_register_lock_ctrl && !lockable_pin_level
    && !$past(lockable_pin_level) |-> disable_register_writable) else $error("read only");
  a_edge_cause: assert property (lock_pin_edge_event |-> $changed(lock_pin_value))
    else $error("edge without change");
endmodule : gpl_checker

// ### dv/gpl_pin_model.sv
// Board side of one pin: a pull-up and an optional external driver
`timescale 1ns/1ps
module gpl_pin_model (
  // Device side
  input wire logic drive,
  input wire logic oe,
  // Board side
  input wire logic ext_en,
  input wire logic ext_val,
  output logic level
);
  // A line released by both sides floats to the pull-up, never to the last driven value
  assign level = oe ? drive : (ext_en ? ext_val : 1'h1);
endmodule : gpl_pin_model

// ### dv/gpl_tb.sv
// Register and pin tests for the two-pin configuration block
`timescale 1ns/1ps
module tb;
  import gpl_pkg::*;
  logic hclk = 1'h0, hresetn = 1'h0, main_power_on_reset = 1'h0, hard_reset = 1'h0;
  logic hsel = 1'h0, hwrite = 1'h0, event_pin_data = 1'h0, lock_pin_data = 1'h0;
  logic power_event_active = 1'h0, share_event_enable = 1'h0, lk_ext = 1'h0;
  logic [9:0] haddr = 10'h000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, r, n;
  logic hready, hreadyout, hresp, event_capable_pin_level, event_capable_pin_drive;
  logic event_capable_pin_oe, event_pin_value, power_event_out_n, lockable_pin_level;
  logic lockable_pin_drive, lockable_pin_oe, lock_pin_value, floppy_parallel_share_select;
  logic lock_pin_edge_event, disable_register_lock_ctrl, disable_register_writable;
  int n_errors = 0, n_tests = 0;
  logic [8:0] cf [6] = '{9'h101, 9'h102, 9'h182, 9'h104, 9'h184, 9'h084};
  logic [1:0] ex [6] = '{2'h0, 2'h3, 2'h0, 2'h2, 2'h2, 2'h0};
  logic [7:0] fc [3] = '{8'h0d, 8'h09, 8'h01};
  logic [1:0] fe [3] = '{2'h2, 2'h2, 2'h0};
  logic lv [2] = '{1'h1, 1'h0};
  assign hready = hreadyout;
  always #2.5 hclk = ~hclk;
  gpl_pin_cfg dut_u (.*);
  gpl_pin_model ev_u (.drive(event_capable_pin_drive), .oe(event_capable_pin_oe),
    .ext_en(1'h0), .ext_val(1'h0), .level(event_capable_pin_level));
  gpl_pin_model lk_u (.drive(lockable_pin_drive), .oe(lockable_pin_oe),
    .ext_en(1'h1), .ext_val(lk_ext), .level(lockable_pin_level));
  task automatic summarize();
    $display("Errors %0d in %0d checks", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", s, e, g);
      n_errors++;
    end
  endtask : chk
  // Bounded wait for hready; a stuck bus ends the run
  task automatic wt();
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
      if (i > 64) begin
        n_errors++;
        summarize();
      end
    end while (hreadyout !== 1'h1);
  endtask : wt
  task automatic ahb(input logic [9:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    {hsel, hwrite, htrans, haddr} <= {1'h1, w, GPL_HTRANS_NONSEQ, a};
    wt();
    {hsel, htrans, hwdata} <= {1'h0, 2'h0, 24'h0, d};
    wt();
    r = hrdata;
    chk("hresp", {31'h0, GPL_HRESP_OKAY}, {31'h0, hresp});
  endtask : ahb
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    ahb(a, 1'h0, 8'h00);
    chk($sformatf("reg %h", a), {24'h0, e}, r);
  endtask : rd
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    rd(GPL_EVT_ADDR, GPL_EVT_RST);
    rd(GPL_LCK_ADDR, GPL_LCK_RST);
    rd(10'h000, 8'h00);
    ahb(GPL_EVT_ADDR, 1'h1, 8'hff);
    rd(GPL_EVT_ADDR, GPL_EVT_MASK);
    foreach (cf[i]) begin
      ahb(GPL_EVT_ADDR, 1'h1, cf[i][7:0]);
      power_event_active <= cf[i][8];
      @(negedge hclk);
      chk("event oe drive", ex[i], {event_capable_pin_oe, event_capable_pin_drive});
    end
    // Released pin floats high; the inverted input then reads low
    repeat (2) @(negedge hclk);
    chk("event value", 32'h1, {31'h0, event_pin_value});
    ahb(GPL_EVT_ADDR, 1'h1, 8'h03);
    @(negedge hclk);
    chk("event value inv", 32'h0, {31'h0, event_pin_value});
    share_event_enable <= 1'h1;
    foreach (fc[i]) begin
      ahb(GPL_LCK_ADDR, 1'h1, fc[i]);
      n = 32'h0;
      repeat (2) begin
        @(posedge hclk);
        lk_ext <= ~lk_ext;
        repeat (4) @(negedge hclk) n += lock_pin_edge_event;
        chk("share select", {31'h0, (fc[i] == 8'h09) & lk_ext},
          {31'h0, floppy_parallel_share_select});
      end
      chk("edge count", fe[i], n);
    end
    // Both resets must free the otherwise permanent lock selection
    for (int k = 0; k < 2; k++) begin
      ahb(GPL_LCK_ADDR, 1'h1, 8'h06);
      ahb(GPL_LCK_ADDR, 1'h1, 8'h8c);
      rd(GPL_LCK_ADDR, 8'h84);
      foreach (lv[j]) begin
        @(posedge hclk);
        lk_ext <= lv[j];
        repeat (3) @(negedge hclk);
        chk("lock value", lv[j], lock_pin_value);
        chk("writable", !lv[j], disable_register_writable);
      end
      @(posedge hclk);
      {main_power_on_reset, hard_reset} <= k ? 2'h2 : 2'h1;
      @(posedge hclk);
      {main_power_on_reset, hard_reset} <= 2'h0;
      rd(GPL_LCK_ADDR, 8'h80);
    end
    summarize();
  end
endmodule : tb
bind gpl_pin_cfg gpl_checker chk_u (.*);
